// File: tw_pkg.sv
// Package with opcodes, flag layout, register offsets, states and reset values of the core.
package tw_pkg;
   // Opcodes handled by the decoder.
   localparam logic [7:0] OP_TRAP = 8'h83;
   localparam logic [7:0] OP_WAIT = 8'h8F;
   localparam logic [7:0] OP_TST_DIR = 8'h3D;
   localparam logic [7:0] OP_TST_A = 8'h4D;
   localparam logic [7:0] OP_TST_X = 8'h5D;
   localparam logic [7:0] OP_TST_IX1 = 8'h6D;
   localparam logic [7:0] OP_TST_IX = 8'h7D;
   localparam logic [7:0] OP_PREFIX = 8'h9E;
   localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
   localparam logic [7:0] OP_LDA_EXT = 8'hC6;
   localparam logic [7:0] OP_LDA_IX2 = 8'hD6;
   // Bit-test-and-branch opcodes occupy the range with a zero high nibble.
   localparam logic [3:0] OP_BRBIT_HI = 4'h0;

   // Flag register bit positions.
   localparam int F_C = 0;
   localparam int F_Z = 1;
   localparam int F_N = 2;
   localparam int F_I = 3;
   localparam int F_H = 4;
   localparam int F_V = 7;
   localparam logic [7:0] FLAGS_RST = 8'h68;

   // Vector locations; the addresses are a free choice of this core.
   localparam logic [15:0] VEC_TRAP = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ = 16'hFFFA;
   localparam logic [15:0] SP_RST = 16'h00FF;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [2:0] PUSH_LAST = 3'h4;

   // Register port offsets.
   localparam logic [3:0] R_ACC = 4'h0;
   localparam logic [3:0] R_IDXL = 4'h1;
   localparam logic [3:0] R_IDXH = 4'h2;
   localparam logic [3:0] R_FLAGS = 4'h3;
   localparam logic [3:0] R_SPL = 4'h4;
   localparam logic [3:0] R_SPH = 4'h5;
   localparam logic [3:0] R_PCL = 4'h6;
   localparam logic [3:0] R_PCH = 4'h7;
   localparam logic [3:0] R_CTRL = 4'h8;
   localparam logic [3:0] R_STAT = 4'h9;
   localparam int CTRL_RUN = 0;

   typedef enum logic [3:0] {
      S_FETCH = 4'b0000,
      S_OP = 4'b0001,
      S_OPR1 = 4'b0010,
      S_OPR2 = 4'b0011,
      S_DATA = 4'b0100,
      S_PUSH = 4'b0101,
      S_VECH = 4'b0110,
      S_VECL = 4'b0111,
      S_WAIT = 4'b1000
   } tw_state_t;

   typedef enum logic [2:0] {
      EA_DIR = 3'b000,
      EA_EXT = 3'b001,
      EA_IX = 3'b010,
      EA_IX1 = 3'b011,
      EA_IX2 = 3'b100,
      EA_SP1 = 3'b101
   } tw_ea_t;
endpackage : tw_pkg

// File: tw_ea.sv
// Effective address former for the direct, extended, indexed and stack forms.
`timescale 1ns/1ps
module tw_ea (
   input wire tw_pkg::tw_ea_t mode,
   input wire logic [15:0] idx,
   input wire logic [15:0] sp,
   input wire logic [7:0] b_hi,
   input wire logic [7:0] b_lo,
   output logic [15:0] ea
);
   always_comb begin
      case (mode)
         tw_pkg::EA_DIR: ea = {tw_pkg::ZERO8, b_lo};
         tw_pkg::EA_EXT: ea = {b_hi, b_lo};
         tw_pkg::EA_IX: ea = idx;
         tw_pkg::EA_IX1: ea = idx + {tw_pkg::ZERO8, b_lo};
         tw_pkg::EA_IX2: ea = idx + {b_hi, b_lo};
         tw_pkg::EA_SP1: ea = sp + {tw_pkg::ZERO8, b_lo};
         default: ea = idx;
      endcase
   end
endmodule : tw_ea

// File: tw_core.sv
// Execution core for the trap, wait and zero-sign test group with its operand fetch.
`timescale 1ns/1ps
module tw_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic irq,
   input wire logic [7:0] mem_rdata,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic halted,
   output logic irq_ack,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   tw_pkg::tw_state_t state_reg, state_next;
   logic [7:0] acc_reg, acc_next;
   logic [15:0] idx_reg, idx_next;
   logic [15:0] sp_reg, sp_next;
   logic [15:0] pc_reg, pc_next;
   logic [7:0] flags_reg, flags_next;
   logic [7:0] op_reg, op_next;
   logic pfx_reg, pfx_next;
   logic [7:0] b1_reg, b1_next;
   logic [7:0] rel_reg, rel_next;
   logic [2:0] cnt_reg, cnt_next;
   logic is_irq_reg, is_irq_next;
   logic run_reg, run_next;
   logic [15:0] addr_reg, addr_next;
   logic rd_reg, rd_next;
   logic wr_reg, wr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic halted_reg, halted_next;
   logic ack_reg, ack_next;
   logic [7:0] rdata_reg, rdata_next;
   tw_pkg::tw_ea_t ea_mode;
   logic [7:0] ea_hi;
   logic [15:0] ea;

   // Negative and zero flags from a value, overflow cleared; other flags kept.
   function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
      logic [7:0] r;
      r = f;
      r[tw_pkg::F_V] = 1'b0;
      r[tw_pkg::F_N] = v[7];
      r[tw_pkg::F_Z] = (v == tw_pkg::ZERO8);
      return r;
   endfunction : nz_flags

   // Branch target from a signed relative offset.
   function automatic logic [15:0] br_target(input logic [15:0] pc, input logic [7:0] rel);
      return pc + {{8{rel[7]}}, rel};
   endfunction : br_target

   tw_ea u_ea (
      .mode(ea_mode),
      .idx(idx_reg),
      .sp(sp_reg),
      .b_hi(ea_hi),
      .b_lo(mem_rdata),
      .ea(ea)
   );

   // Address mode selection is made from the opcode held and the state.
   always_comb begin
      ea_hi = b1_reg;
      ea_mode = tw_pkg::EA_DIR;
      if (state_reg == tw_pkg::S_OPR1) begin
         if (op_reg == tw_pkg::OP_TST_IX1 && pfx_reg) begin
            ea_mode = tw_pkg::EA_SP1;
         end else if (op_reg == tw_pkg::OP_TST_IX1) begin
            ea_mode = tw_pkg::EA_IX1;
         end
      end else if (state_reg == tw_pkg::S_OPR2) begin
         if (op_reg == tw_pkg::OP_LDA_EXT) begin
            ea_mode = tw_pkg::EA_EXT;
         end else if (op_reg == tw_pkg::OP_LDA_IX2) begin
            ea_mode = tw_pkg::EA_IX2;
         end else begin
            ea_mode = tw_pkg::EA_DIR;
            ea_hi = tw_pkg::ZERO8;
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      acc_next = acc_reg;
      idx_next = idx_reg;
      sp_next = sp_reg;
      pc_next = pc_reg;
      flags_next = flags_reg;
      op_next = op_reg;
      pfx_next = pfx_reg;
      b1_next = b1_reg;
      rel_next = rel_reg;
      cnt_next = cnt_reg;
      is_irq_next = is_irq_reg;
      run_next = run_reg;
      addr_next = addr_reg;
      rd_next = 1'b0;
      wr_next = 1'b0;
      wdata_next = wdata_reg;
      halted_next = halted_reg;
      ack_next = 1'b0;
      case (state_reg)
         tw_pkg::S_FETCH: begin
            if (irq && !flags_reg[tw_pkg::F_I]) begin
               state_next = tw_pkg::S_PUSH;
               is_irq_next = 1'b1;
               cnt_next = 3'h0;
            end else if (run_reg) begin
               addr_next = pc_reg;
               rd_next = 1'b1;
               pc_next = pc_reg + 16'h0001;
               pfx_next = 1'b0;
               state_next = tw_pkg::S_OP;
            end
         end
         tw_pkg::S_OP: begin
            op_next = mem_rdata;
            state_next = tw_pkg::S_FETCH;
            if (mem_rdata == tw_pkg::OP_PREFIX && !pfx_reg) begin
               pfx_next = 1'b1;
               addr_next = pc_reg;
               rd_next = 1'b1;
               pc_next = pc_reg + 16'h0001;
               state_next = tw_pkg::S_OP;
            end else if (pfx_reg) begin
               if (mem_rdata == tw_pkg::OP_TST_IX1) begin
                  addr_next = pc_reg;
                  rd_next = 1'b1;
                  pc_next = pc_reg + 16'h0001;
                  state_next = tw_pkg::S_OPR1;
               end
            end else if (mem_rdata == tw_pkg::OP_TST_A) begin
               flags_next = nz_flags(flags_reg, acc_reg);
            end else if (mem_rdata == tw_pkg::OP_TST_X) begin
               flags_next = nz_flags(flags_reg, idx_reg[7:0]);
            end else if (mem_rdata == tw_pkg::OP_WAIT) begin
               flags_next[tw_pkg::F_I] = 1'b0;
               halted_next = 1'b1;
               state_next = tw_pkg::S_WAIT;
            end else if (mem_rdata == tw_pkg::OP_TRAP) begin
               is_irq_next = 1'b0;
               cnt_next = 3'h0;
               state_next = tw_pkg::S_PUSH;
            end else if (mem_rdata == tw_pkg::OP_TST_IX) begin
               addr_next = idx_reg;
               rd_next = 1'b1;
               state_next = tw_pkg::S_DATA;
            end else if (mem_rdata == tw_pkg::OP_TST_DIR || mem_rdata == tw_pkg::OP_TST_IX1
                  || mem_rdata == tw_pkg::OP_LDA_EXT || mem_rdata == tw_pkg::OP_LDA_IX2
                  || mem_rdata == tw_pkg::OP_CBEQ_IXP
                  || mem_rdata[7:4] == tw_pkg::OP_BRBIT_HI) begin
               addr_next = pc_reg;
               rd_next = 1'b1;
               pc_next = pc_reg + 16'h0001;
               state_next = tw_pkg::S_OPR1;
            end
         end
         tw_pkg::S_OPR1: begin
            b1_next = mem_rdata;
            state_next = tw_pkg::S_DATA;
            rd_next = 1'b1;
            if (op_reg == tw_pkg::OP_CBEQ_IXP) begin
               rel_next = mem_rdata;
               addr_next = idx_reg;
               idx_next = idx_reg + 16'h0001;
            end else if (op_reg == tw_pkg::OP_TST_DIR || op_reg == tw_pkg::OP_TST_IX1) begin
               addr_next = ea;
            end else begin
               // Third instruction byte follows: low address byte or branch offset.
               addr_next = pc_reg;
               pc_next = pc_reg + 16'h0001;
               state_next = tw_pkg::S_OPR2;
            end
         end
         tw_pkg::S_OPR2: begin
            rd_next = 1'b1;
            state_next = tw_pkg::S_DATA;
            if (op_reg[7:4] == tw_pkg::OP_BRBIT_HI) begin
               rel_next = mem_rdata;
               addr_next = {tw_pkg::ZERO8, b1_reg};
            end else begin
               addr_next = ea;
            end
         end
         tw_pkg::S_DATA: begin
            state_next = tw_pkg::S_FETCH;
            if (op_reg == tw_pkg::OP_LDA_EXT || op_reg == tw_pkg::OP_LDA_IX2) begin
               acc_next = mem_rdata;
               flags_next = nz_flags(flags_reg, mem_rdata);
            end else if (op_reg == tw_pkg::OP_CBEQ_IXP) begin
               if (acc_reg == mem_rdata) begin
                  pc_next = br_target(pc_reg, rel_reg);
               end
            end else if (op_reg[7:4] == tw_pkg::OP_BRBIT_HI) begin
               // Even opcodes branch on a set bit, odd ones on a clear bit.
               flags_next[tw_pkg::F_C] = mem_rdata[op_reg[3:1]];
               if (mem_rdata[op_reg[3:1]] != op_reg[0]) begin
                  pc_next = br_target(pc_reg, rel_reg);
               end
            end else begin
               flags_next = nz_flags(flags_reg, mem_rdata);
            end
         end
         tw_pkg::S_PUSH: begin
            addr_next = sp_reg;
            wr_next = 1'b1;
            sp_next = sp_reg - 16'h0001;
            case (cnt_reg)
               3'h0: wdata_next = pc_reg[7:0];
               3'h1: wdata_next = pc_reg[15:8];
               3'h2: wdata_next = idx_reg[7:0];
               3'h3: wdata_next = acc_reg;
               default: wdata_next = flags_reg;
            endcase
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == tw_pkg::PUSH_LAST) begin
               state_next = tw_pkg::S_VECH;
            end
         end
         tw_pkg::S_VECH: begin
            // The stacked flags already left; the mask is set for the handler.
            flags_next[tw_pkg::F_I] = 1'b1;
            addr_next = is_irq_reg ? tw_pkg::VEC_IRQ : tw_pkg::VEC_TRAP;
            rd_next = 1'b1;
            state_next = tw_pkg::S_VECL;
            cnt_next = 3'h0;
         end
         tw_pkg::S_VECL: begin
            if (cnt_reg == 3'h0) begin
               pc_next[15:8] = mem_rdata;
               addr_next = addr_reg + 16'h0001;
               rd_next = 1'b1;
               cnt_next = 3'h1;
            end else begin
               pc_next[7:0] = mem_rdata;
               ack_next = is_irq_reg;
               state_next = tw_pkg::S_FETCH;
            end
         end
         tw_pkg::S_WAIT: begin
            // No memory traffic while stopped; only register port writes or an unmasked interrupt change registers.
            if (irq && !flags_reg[tw_pkg::F_I]) begin
               halted_next = 1'b0;
               is_irq_next = 1'b1;
               cnt_next = 3'h0;
               state_next = tw_pkg::S_PUSH;
            end
         end
         default: state_next = tw_pkg::S_FETCH;
      endcase
      // Software writes take priority over the core in the same cycle.
      if (reg_wr) begin
         if (reg_addr == tw_pkg::R_ACC) begin
            acc_next = reg_wdata;
         end else if (reg_addr == tw_pkg::R_IDXL) begin
            idx_next[7:0] = reg_wdata;
         end else if (reg_addr == tw_pkg::R_IDXH) begin
            idx_next[15:8] = reg_wdata;
         end else if (reg_addr == tw_pkg::R_FLAGS) begin
            flags_next = reg_wdata;
         end else if (reg_addr == tw_pkg::R_SPL) begin
            sp_next[7:0] = reg_wdata;
         end else if (reg_addr == tw_pkg::R_SPH) begin
            sp_next[15:8] = reg_wdata;
         end else if (reg_addr == tw_pkg::R_PCL) begin
            pc_next[7:0] = reg_wdata;
         end else if (reg_addr == tw_pkg::R_PCH) begin
            pc_next[15:8] = reg_wdata;
         end else if (reg_addr == tw_pkg::R_CTRL) begin
            run_next = reg_wdata[tw_pkg::CTRL_RUN];
         end
      end
      rdata_next = tw_pkg::ZERO8;
      if (reg_rd) begin
         if (reg_addr == tw_pkg::R_ACC) begin
            rdata_next = acc_reg;
         end else if (reg_addr == tw_pkg::R_IDXL) begin
            rdata_next = idx_reg[7:0];
         end else if (reg_addr == tw_pkg::R_IDXH) begin
            rdata_next = idx_reg[15:8];
         end else if (reg_addr == tw_pkg::R_FLAGS) begin
            rdata_next = flags_reg;
         end else if (reg_addr == tw_pkg::R_SPL) begin
            rdata_next = sp_reg[7:0];
         end else if (reg_addr == tw_pkg::R_SPH) begin
            rdata_next = sp_reg[15:8];
         end else if (reg_addr == tw_pkg::R_PCL) begin
            rdata_next = pc_reg[7:0];
         end else if (reg_addr == tw_pkg::R_PCH) begin
            rdata_next = pc_reg[15:8];
         end else if (reg_addr == tw_pkg::R_CTRL) begin
            rdata_next = {7'h00, run_reg};
         end else if (reg_addr == tw_pkg::R_STAT) begin
            rdata_next = {3'h0, halted_reg, state_reg};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= tw_pkg::S_FETCH;
         acc_reg <= tw_pkg::ZERO8;
         idx_reg <= tw_pkg::ZERO16;
         sp_reg <= tw_pkg::SP_RST;
         pc_reg <= tw_pkg::PC_RST;
         flags_reg <= tw_pkg::FLAGS_RST;
         op_reg <= tw_pkg::ZERO8;
         pfx_reg <= 1'b0;
         b1_reg <= tw_pkg::ZERO8;
         rel_reg <= tw_pkg::ZERO8;
         cnt_reg <= 3'h0;
         is_irq_reg <= 1'b0;
         run_reg <= 1'b0;
         addr_reg <= tw_pkg::ZERO16;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         wdata_reg <= tw_pkg::ZERO8;
         halted_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdata_reg <= tw_pkg::ZERO8;
      end else begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         idx_reg <= idx_next;
         sp_reg <= sp_next;
         pc_reg <= pc_next;
         flags_reg <= flags_next;
         op_reg <= op_next;
         pfx_reg <= pfx_next;
         b1_reg <= b1_next;
         rel_reg <= rel_next;
         cnt_reg <= cnt_next;
         is_irq_reg <= is_irq_next;
         run_reg <= run_next;
         addr_reg <= addr_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         wdata_reg <= wdata_next;
         halted_reg <= halted_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign mem_addr = addr_reg;
   assign mem_rd = rd_reg;
   assign mem_wr = wr_reg;
   assign mem_wdata = wdata_reg;
   assign halted = halted_reg;
   assign irq_ack = ack_reg;
   assign reg_rdata = rdata_reg;
endmodule : tw_core

// File: tw_core_asserts.sv
// Concurrent checks on the ports of the trap, wait and zero-sign test core.
`timescale 1ns/1ps
module tw_core_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic irq,
   input wire logic [7:0] mem_rdata,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic halted,
   input wire logic irq_ack,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   halt_quiet_a: assert property (halted && $past(halted) |-> !mem_rd && !mem_wr)
      else $error("memory access while halted");
   halt_hold_a: assert property ($fell(halted) && !$past(rst) |-> $past(irq))
      else $error("halt left without an interrupt");
   wait_entry_a: assert property ($rose(halted) |-> $past(mem_rdata) == tw_pkg::OP_WAIT)
      else $error("halt entered without the wait opcode");
   irq_wake_a: assert property (halted && irq |-> ##[1:4] mem_wr)
      else $error("interrupt did not end the halt");
   push_run_a: assert property ($rose(mem_wr) |-> mem_wr [*5] ##1 !mem_wr)
      else $error("stacking is not five writes");
   push_down_a: assert property (mem_wr && $past(mem_wr) |->
      mem_addr == $past(mem_addr) - 16'h0001)
      else $error("stack address did not step down");
   vec_fetch_a: assert property ($fell(mem_wr) |->
      ##[0:2] (mem_rd && mem_addr >= tw_pkg::VEC_IRQ))
      else $error("no vector read after stacking");
   vec_order_a: assert property (mem_rd && mem_addr == tw_pkg::VEC_TRAP |->
      ##[1:2] (mem_rd && mem_addr == 16'hFFFD))
      else $error("vector low byte not read after high byte");
endmodule : tw_core_asserts

bind tw_core tw_core_asserts chk_i (.clk(clk), .rst(rst), .irq(irq), .mem_rdata(mem_rdata),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
   .halted(halted), .irq_ack(irq_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// File: tw_mem_model.sv
// Behavioural program and stack memory for the core, with a log of every write.
`timescale 1ns/1ps
module tw_mem_model (
   input wire logic clk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] idle_q;
   logic [23:0] wr_log [$];
   initial begin
      idle_q = 8'h00;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h9D;
      end
   end
   // The core takes read data in the same cycle that its read strobe stands, so reads are
   // answered at once. Outside a read the lines flip each cycle, so a stray sample cannot pass.
   assign mem_rdata = mem_rd ? mem[mem_addr] : idle_q;
   always @(posedge clk) begin
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
         wr_log.push_back({mem_addr, mem_wdata});
      end
      idle_q <= ~idle_q;
   end
endmodule : tw_mem_model

// File: cpu_trap_wait_test_execution_bench.sv
// Self-checking bench for the trap, wait and zero-sign test core.
`timescale 1ns/1ps
module cpu_trap_wait_test_execution_bench;
   logic clk, rst, irq, mem_rd, mem_wr, halted, irq_ack, reg_wr, reg_rd;
   logic [7:0] mem_rdata, mem_wdata, reg_wdata, reg_rdata;
   logic [15:0] mem_addr;
   logic [3:0] reg_addr;
   int bad_count = 0;
   int samples_checked = 0;
   int seed = 84488;

   tw_core dut (.clk(clk), .rst(rst), .irq(irq), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .halted(halted),
      .irq_ack(irq_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   tw_mem_model mem_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_sim();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic reg_w(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_w

   task automatic reg_r(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_r

   // Sampled 1 ns after the edge so the edge's own updates have landed.
   task automatic wait_for(input int what);
      logic hit;
      for (int n = 0; n < 200; n++) begin
         @(posedge clk);
         #1;
         hit = (what == 0) ? halted === 1'b1 : (what == 1) ? irq_ack === 1'b1
            : mem_i.wr_log.size() >= 5;
         if (hit) begin
            return;
         end
      end
      bad_count++;
      end_sim();
   endtask : wait_for

   task automatic restart(input logic [7:0] a, x, h, f);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      reg_w(tw_pkg::R_ACC, a);
      reg_w(tw_pkg::R_IDXL, x);
      reg_w(tw_pkg::R_IDXH, h);
      reg_w(tw_pkg::R_FLAGS, f);
   endtask : restart

   function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] v);
      return (f & 8'h79) | {5'h00, v[7], v == 8'h00, 1'b0};
   endfunction : nz

   initial begin
      logic [7:0] a, x, h, f, o, m, v, d, xa, fe, fm;
      logic [7:0] prog [0:5];
      logic [15:0] hx, ea, xhx, pc;
      int len;
      rst = 1'b1;
      irq = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         reg_r(i[3:0], d);
         chk("reset reg", d, (i == 3) ? 8'h68 : (i == 4) ? 8'hFF : 8'h00);
      end
      for (int k = 0; k < 20; k++) begin
         a = 8'($random(seed));
         x = 8'($random(seed));
         h = 8'($random(seed)) | 8'h01;
         o = 8'($random(seed)) | 8'h40;
         m = 8'($random(seed));
         f = 8'($random(seed)) | 8'h60;
         hx = {h, x};
         v = m;
         xa = a;
         xhx = hx;
         fm = 8'hFF;
         prog[1] = o;
         case (k % 10)
            0: begin prog[0] = 8'h3D; len = 2; ea = {8'h00, o}; end
            1: begin prog[0] = 8'h4D; len = 1; v = a; end
            2: begin prog[0] = 8'h5D; len = 1; v = x; end
            3: begin prog[0] = 8'h6D; len = 2; ea = hx + {8'h00, o}; end
            4: begin prog[0] = 8'h7D; len = 1; ea = hx; end
            5: begin prog[0] = 8'h9E; prog[1] = 8'h6D; prog[2] = o; len = 3;
               ea = tw_pkg::SP_RST + {8'h00, o}; end
            6: begin prog[0] = 8'hC6; prog[1] = h; prog[2] = o; len = 3; ea = {h, o}; xa = m; end
            7: begin prog[0] = 8'hD6; prog[1] = h; prog[2] = o; len = 3; ea = hx + {h, o}; xa = m; end
            8: begin prog[0] = 8'h71; prog[1] = 8'h00; len = 2; ea = hx; xhx = hx + 16'h0001; end
            default: begin prog[0] = 8'h00; prog[2] = 8'h02; prog[3] = 8'h8F; prog[4] = 8'h9D;
               len = 5; ea = {8'h00, o}; fm = 8'hFE; end
         endcase
         fe = ((k % 10 < 8) ? nz(f, v) : f) & 8'hF7;
         pc = (k % 10 == 9) ? (m[0] ? 16'h0006 : 16'h0004) : 16'(len + 1);
         restart(a, x, h, f);
         mem_i.mem[ea] = m;
         for (int j = 0; j < len; j++) begin
            mem_i.mem[j] = prog[j];
         end
         mem_i.mem[len] = tw_pkg::OP_WAIT;
         reg_w(tw_pkg::R_CTRL, 8'h01);
         wait_for(0);
         reg_r(tw_pkg::R_ACC, d);
         chk("acc", d, xa);
         reg_r(tw_pkg::R_IDXL, d);
         chk("index low", d, xhx[7:0]);
         reg_r(tw_pkg::R_IDXH, d);
         chk("index high", d, xhx[15:8]);
         reg_r(tw_pkg::R_FLAGS, d);
         chk("flags", d & fm, fe & fm);
         reg_r(tw_pkg::R_PCL, d);
         chk("pc low", d, pc[7:0]);
      end
      f = (8'($random(seed)) & 8'h97) | 8'h60;
      restart(a, x, h, f);
      mem_i.mem[0] = tw_pkg::OP_TRAP;
      mem_i.mem[16'hFFFC] = 8'h00;
      mem_i.mem[16'hFFFD] = 8'h40;
      mem_i.mem[16'h0040] = tw_pkg::OP_WAIT;
      mem_i.mem[16'hFFFA] = 8'h00;
      mem_i.mem[16'hFFFB] = 8'h50;
      mem_i.mem[16'h0050] = tw_pkg::OP_WAIT;
      mem_i.wr_log.delete();
      reg_w(tw_pkg::R_CTRL, 8'h01);
      // The interrupt rises mid-trap; only a set mask keeps it out until the wait.
      wait_for(2);
      @(posedge clk);
      irq <= 1'b1;
      wait_for(1);
      @(posedge clk);
      irq <= 1'b0;
      wait_for(0);
      chk("push count", mem_i.wr_log.size(), 24'h00_000A);
      for (int i = 0; i < 10; i++) begin
         case (i % 5)
            0: d = (i < 5) ? 8'h01 : 8'h41;
            1: d = 8'h00;
            2: d = x;
            3: d = a;
            default: d = f;
         endcase
         chk("push", mem_i.wr_log[i], {16'h00FF - i[15:0], d});
      end
      reg_r(tw_pkg::R_PCL, d);
      chk("pc after irq", d, 8'h51);
      reg_r(tw_pkg::R_SPL, d);
      chk("stack low", d, 8'hF5);
      reg_r(tw_pkg::R_FLAGS, d);
      chk("flags after irq", d, f);
      end_sim();
   end
endmodule : cpu_trap_wait_test_execution_bench
